// ==== logic/ms_tick_gen.sv ====
// Millisecond tick divider.
// Assumes the core clock rate given in the package.
module ms_tick_gen #(
    parameter logic [panel_seq_pkg::PRE_W-1:0] TICK_LAST = panel_seq_pkg::PRE_LAST  // Ms wrap
) (
    input  wire logic core_clk,  // Core clock
    input  wire logic rst_n,     // Synchronous reset, low active
    output logic      msTick     // One-cycle pulse each ms
);

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    logic [panel_seq_pkg::PRE_W-1:0] pre_ff;  // Cycle count within a ms
    wire                             preWrap = (pre_ff == TICK_LAST);  // Last cycle of a ms

    // Free-running count of cycles
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pre_ff <= '0;
            msTick <= 1'b0;
        end else begin
            pre_ff <= preWrap ? '0 : pre_ff + 1'b1;
            msTick <= preWrap;
        end
    end

endmodule : ms_tick_gen

// ==== logic/panel_power_video_sequencer.sv ====
// Sink side power-on and video sequencer for an embedded panel.
// Assumes pins from the source arrive asynchronously, decoded video flags
// come from link logic outside, and a single 50 MHz core clock.
//
// Notes on behaviour
// - Black video within 200 ms of supply.
// - Hot-plug high within 200 ms of supply.
// - AUX ready before hot-plug goes high.
// - Within 50 ms validate, show, set status.
// - Video end clears status, black video.
// - Black video on power-on and no-stream flag.
// - Automatic black video may be disabled.
// - Tolerate early AUX polls, answer in time.
module panel_power_video_sequencer #(
    // Last cycle of each ms; a bench may shorten the ms to save run time
    parameter logic [panel_seq_pkg::PRE_W-1:0] TICK_LAST = panel_seq_pkg::PRE_LAST
) (
    input  wire logic                      core_clk,        // Core clock
    input  wire logic                      rst_n,           // Sync reset
    input  wire logic                      panelLogicSupply,// Supply good pin
    input  wire logic                      videoValid,      // Video stream seen
    input  wire logic                      noVideoFlag,     // VB-ID bit 3 seen
    input  wire logic                      blackDisable,    // Debug: no auto black
    output logic                           hpdOut,          // Hot-plug detect pin
    output logic                           auxEnable,       // AUX may answer
    output logic                           blackVideo,      // Generate black video
    output logic                           sinkStatus,      // Status bit 0 of 00205h
    output panel_seq_pkg::sink_stat_t      statBus          // Grouped status
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [2:0] syncA_ff;  // First stage
    logic [2:0] syncB_ff;  // Second stage, read by logic
    wire  [2:0] rawIn = {noVideoFlag, videoValid, panelLogicSupply};

    // Two flops per asynchronous input
    // The first stage may go metastable, so only the second one is read
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            syncA_ff <= 3'h0;
            syncB_ff <= 3'h0;
        end else begin
            syncA_ff <= rawIn;
            syncB_ff <= syncA_ff;
        end
    end

    wire supplyUp = syncB_ff[0];  // Supply present
    wire vidIn    = syncB_ff[1];  // Video arriving
    wire noVid    = syncB_ff[2];  // No-stream flag

    // ------------------------------------------------------------------
    // Millisecond time base
    // ------------------------------------------------------------------
    logic msTick;  // One pulse per ms

    ms_tick_gen #(
        .TICK_LAST (TICK_LAST)
    ) u_tick (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .msTick   (msTick)
    );

    // ------------------------------------------------------------------
    // State machine and delay counter
    // ------------------------------------------------------------------
    panel_seq_pkg::seq_state_t        state_ff;  // Current state
    panel_seq_pkg::seq_state_t        nxt_state; // Next state
    logic [panel_seq_pkg::MS_CNT_W-1:0] ms_ff;   // Elapsed ms in state
    logic                               stChange;// State is changing

    wire videoGone = !vidIn || noVid;  // Video end condition
    wire hpdDue    = msTick && (ms_ff >= panel_seq_pkg::HPD_MS - 1'b1);
    wire validDue  = msTick && (ms_ff >= panel_seq_pkg::VALID_MS - 1'b1);

    // Next state selection
    // A video loss during the check sends the machine back to black, so a
    // stream that flickers on and off is never shown half validated; the
    // check span then starts again from zero on the next arrival.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            panel_seq_pkg::ST_OFF: begin
                // Supply rising starts the wake delay
                if (supplyUp) begin
                    nxt_state = panel_seq_pkg::ST_WAKE;
                end
            end
            panel_seq_pkg::ST_WAKE: begin
                // Raise hot-plug after the fixed delay
                if (hpdDue) begin
                    nxt_state = panel_seq_pkg::ST_READY;
                end
            end
            panel_seq_pkg::ST_READY: begin
                // Source trains after hot-plug; wait for video
                if (vidIn && !noVid) begin
                    nxt_state = panel_seq_pkg::ST_CHECK;
                end
            end
            panel_seq_pkg::ST_CHECK: begin
                // Abort on video loss, show after check span
                if (videoGone) begin
                    nxt_state = panel_seq_pkg::ST_READY;
                end else if (validDue) begin
                    nxt_state = panel_seq_pkg::ST_SHOW;
                end
            end
            panel_seq_pkg::ST_SHOW: begin
                // End of video returns to black
                if (videoGone) begin
                    nxt_state = panel_seq_pkg::ST_READY;
                end
            end
            default: begin
                nxt_state = panel_seq_pkg::ST_OFF;
            end
        endcase
        // Supply loss overrides everything
        if (!supplyUp) begin
            nxt_state = panel_seq_pkg::ST_OFF;
        end
    end

    assign stChange = (nxt_state != state_ff);

    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= panel_seq_pkg::ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Ms counter, restarts on each state change
    // Saturates, so a long stay in one state never wraps to a false deadline
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ms_ff <= panel_seq_pkg::CNT_RST;
        end else if (stChange) begin
            ms_ff <= panel_seq_pkg::CNT_RST;
        end else if (msTick && (ms_ff != '1)) begin
            ms_ff <= ms_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------------
    // Outputs are decoded from the next state, so they move on the same
    // edge as the state register; decoding the current state would add a
    // cycle to every deadline and let hot-plug trail the state.

    // States in which hot-plug stands high
    function automatic logic hpd_state(input panel_seq_pkg::seq_state_t st);
        hpd_state = (st == panel_seq_pkg::ST_READY) ||
                    (st == panel_seq_pkg::ST_CHECK) ||
                    (st == panel_seq_pkg::ST_SHOW);
    endfunction : hpd_state

    wire poweredSt = (nxt_state != panel_seq_pkg::ST_OFF);  // Supply present
    wire hpdSt     = hpd_state(nxt_state);                   // Hot-plug due
    wire showSt    = (nxt_state == panel_seq_pkg::ST_SHOW);  // Video on display

    // AUX enabled from supply up, well before hot-plug
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            auxEnable <= 1'b0;  // Quiet in reset
        end else begin
            auxEnable <= poweredSt;
        end
    end

    // Hot-plug level
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hpdOut <= 1'b0;  // Low in reset
        end else begin
            hpdOut <= hpdSt;
        end
    end

    // Black from power-on until video shown, unless debug off
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            blackVideo <= 1'b0;  // Off in reset
        end else begin
            blackVideo <= poweredSt && !showSt && !blackDisable;
        end
    end

    // Sink status bit follows the shown state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sinkStatus <= 1'b0;  // Clear in reset
        end else begin
            sinkStatus <= showSt;
        end
    end

    // Grouped copy for the user side; built from the flops, so it never
    // disagrees with the single outputs
    assign statBus = '{hpd: hpdOut, auxReady: auxEnable,
                       blackVideo: blackVideo, sinkStatus: sinkStatus};

endmodule : panel_power_video_sequencer

// ==== logic/panel_seq_pkg.sv ====
// Package for the panel power and video sequencer.
// Assumes a single 50 MHz core clock and a synchronous active-low reset.
package panel_seq_pkg;

    // ------------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 50000000;  // Core clock rate
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;  // Cycles in one ms
    localparam int unsigned HPD_MAX_MS    = 200;  // Supply up to hot-plug high
    localparam int unsigned BLACK_MAX_MS  = 200;  // Supply up to black video
    localparam int unsigned VALID_MAX_MS  = 50;   // Video arrival to shown
    localparam int unsigned HPD_DLY_MS    = 20;   // Chosen hot-plug delay
    localparam int unsigned VALID_DLY_MS  = 40;   // Chosen video check span
    localparam int unsigned MS_CNT_W      = 16;   // Tick counter width
    localparam int unsigned PRE_W         = 16;   // Prescaler width
    localparam logic [PRE_W-1:0]    PRE_LAST  = PRE_W'(CYC_PER_MS - 1);
    localparam logic [MS_CNT_W-1:0] HPD_MS    = MS_CNT_W'(HPD_DLY_MS);
    localparam logic [MS_CNT_W-1:0] VALID_MS  = MS_CNT_W'(VALID_DLY_MS);
    localparam logic [MS_CNT_W-1:0] CNT_RST   = 16'h0000;  // Counter reset

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,  // Panel supply down
        ST_WAKE  = 3'b001,  // Supply up, waiting before hot-plug
        ST_READY = 3'b010,  // Hot-plug high, black video
        ST_CHECK = 3'b011,  // Video seen, being validated
        ST_SHOW  = 3'b100   // Valid video on display
    } seq_state_t;

    // ------------------------------------------------------------------
    // Status carried to the user side
    // ------------------------------------------------------------------
    typedef struct packed {
        logic hpd;        // Hot-plug detect level
        logic auxReady;   // AUX may serve transactions
        logic blackVideo; // Black video being generated
        logic sinkStatus; // Sink status bit 0 of 00205h
    } sink_stat_t;

endpackage : panel_seq_pkg

// ==== tb/panel_power_video_sequencer_tb.sv ====
// Bench for the panel power and video sequencer.
// Assumes the source model and the checker in tb.
module panel_power_video_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic vid;
        logic noVid;
        logic dis;
        logic [7:0] ms;
        panel_seq_pkg::sink_stat_t exp;
    } row_t;
    localparam int MS = 20; // Cycles per ms, shortened to keep runs brief
    localparam row_t ROWS [6] = '{
        '{1'b0, 1'b0, 1'b0, 8'h01, 4'he}, // No video: black
        '{1'b1, 1'b0, 1'b0, 8'h2d, 4'hd}, // Shown
        '{1'b1, 1'b1, 1'b0, 8'h01, 4'he}, // Flag: black
        '{1'b0, 1'b0, 1'b1, 8'h01, 4'hc}, // Debug: dark
        '{1'b1, 1'b0, 1'b0, 8'h5a, 4'hd}, // Shown again, backlight lit
        '{1'b0, 1'b0, 1'b0, 8'h3c, 4'he}  // End: backlight dark first, then black
    };
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic powerReq = 1'b0;
    logic videoReq = 1'b0;
    logic noVideoFlag = 1'b0;
    logic blackDisable = 1'b0;
    logic supply, video, hpdOut, auxEnable, blackVideo, sinkStatus;
    panel_seq_pkg::sink_stat_t statBus;
    int n_mismatch = 0;
    int n_compared = 0;
    int k;
    always #10 core_clk = ~core_clk;
    source_model #(.CYC_MS(MS)) source_model_i (.core_clk(core_clk), .powerReq(powerReq),
        .videoReq(videoReq), .hpdIn(hpdOut), .supplyOut(supply), .videoOut(video));
    panel_power_video_sequencer #(.TICK_LAST(panel_seq_pkg::PRE_W'(MS - 1)))
        panel_power_video_sequencer_i (.core_clk(core_clk),
        .rst_n(rst_n), .panelLogicSupply(supply), .videoValid(video),
        .noVideoFlag(noVideoFlag), .blackDisable(blackDisable), .hpdOut(hpdOut),
        .auxEnable(auxEnable), .blackVideo(blackVideo), .sinkStatus(sinkStatus),
        .statBus(statBus));
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : tick
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s %h/%h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic results;
        $display("Counts: %0d compared, %0d bad", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    // Main sequence
    initial begin
        tick(5);
        chk(statBus, 4'h0, "reset");
        tick(1);
        rst_n = 1'b1;
        tick(2);
        chk(statBus, 4'h0, "unpowered");
        $display("Test reset done");
        powerReq = 1'b1;
        tick(5);
        chk(statBus, 4'h6, "power-up");
        k = 0;
        while (hpdOut !== 1'b1 && k < 200 * MS) begin
            tick(1);
            k++;
        end
        chk({3'h0, k < 200 * MS}, 4'h1, "hpd late");
        $display("Test power-up done");
        foreach (ROWS[i]) begin
            videoReq = ROWS[i].vid;
            noVideoFlag = ROWS[i].noVid;
            blackDisable = ROWS[i].dis;
            tick(ROWS[i].ms * MS);
            chk(statBus, ROWS[i].exp, "row");
            $display("Test row %0d done", i);
        end
        powerReq = 1'b0;
        tick(5);
        chk(statBus, 4'h0, "power-off");
        $display("Test power-off done");
        results();
    end
    // Watchdog
    initial begin
        tick(400 * MS);
        n_mismatch++;
        results();
    end
endmodule : panel_power_video_sequencer_tb
bind panel_power_video_sequencer panel_seq_properties #(.TICK_LAST(TICK_LAST)) panel_seq_properties_i (
    .core_clk(core_clk), .rst_n(rst_n), .panelLogicSupply(panelLogicSupply),
    .videoValid(videoValid), .noVideoFlag(noVideoFlag), .blackDisable(blackDisable),
    .hpdOut(hpdOut), .auxEnable(auxEnable), .blackVideo(blackVideo),
    .sinkStatus(sinkStatus), .statBus(statBus));

// ==== tb/panel_seq_properties.sv ====
// Port checker for the panel sequencer.
// Assumes a bind onto panel_power_video_sequencer.
module panel_seq_properties #(
    parameter logic [panel_seq_pkg::PRE_W-1:0] TICK_LAST = panel_seq_pkg::PRE_LAST
) (
    input wire logic                      core_clk,
    input wire logic                      rst_n,
    input wire logic                      panelLogicSupply,
    input wire logic                      videoValid,
    input wire logic                      noVideoFlag,
    input wire logic                      blackDisable,
    input wire logic                      hpdOut,
    input wire logic                      auxEnable,
    input wire logic                      blackVideo,
    input wire logic                      sinkStatus,
    input wire panel_seq_pkg::sink_stat_t statBus
);
    localparam int unsigned CYC_MS   = int'(TICK_LAST) + 1; // Cycles in one ms
    localparam int unsigned HPD_LIM  = 200 * CYC_MS;        // 200 ms
    localparam int unsigned SHOW_LIM = 50 * CYC_MS;         // 50 ms
    logic [23:0] hpdWait_ff;            // Supply up, hot-plug low
    logic [23:0] showWait_ff;           // Video up, not shown
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Deadline counters, cleared when the wait ends
    always_ff @(posedge core_clk) begin
        hpdWait_ff <= (rst_n && panelLogicSupply && !hpdOut) ? hpdWait_ff + 24'h000001
            : 24'h000000;
        showWait_ff <= (rst_n && videoValid && !noVideoFlag && hpdOut && !sinkStatus)
            ? showWait_ff + 24'h000001 : 24'h000000;
    end
    a_stat_copy: assert property (statBus == {hpdOut, auxEnable, blackVideo, sinkStatus})
        else $error("status bus differs");
    a_aux_at_hpd: assert property (hpdOut |-> auxEnable)
        else $error("hot-plug without aux");
    a_hpd_deadline: assert property (hpdWait_ff < HPD_LIM)
        else $error("hot-plug late");
    a_black_early: assert property ($rose(panelLogicSupply) && !blackDisable |-> ##[1:4] blackVideo)
        else $error("black video late");
    a_show_deadline: assert property (showWait_ff < SHOW_LIM)
        else $error("video shown late");
    a_show_no_black: assert property (sinkStatus |-> !blackVideo && hpdOut)
        else $error("status with black");
    a_end_clears: assert property ($fell(videoValid) |-> ##[1:4] !sinkStatus)
        else $error("status kept after end");
    a_flag_black: assert property ($rose(noVideoFlag) && !blackDisable && panelLogicSupply
        |-> ##[1:4] (blackVideo && !sinkStatus))
        else $error("flag ignored");
    a_debug_dark: assert property (blackDisable && $past(blackDisable) |-> !blackVideo)
        else $error("black despite disable");
    a_supply_drop: assert property ($fell(panelLogicSupply) |-> ##[1:4] statBus == 4'h0)
        else $error("outputs kept after drop");
    c_hpd: cover property ($rose(hpdOut));
    c_show: cover property ($rose(sinkStatus));
    c_drop: cover property ($fell(auxEnable));
endmodule : panel_seq_properties

// ==== tb/source_model.sv ====
// Behavioural source that powers the panel and sends video.
// Assumes the bench asks for power and video by level.
module source_model #(
    parameter int CYC_MS = 50000  // Clock cycles in one ms
) (
    input  wire logic core_clk,
    input  wire logic powerReq,  // Bench wants power
    input  wire logic videoReq,  // Bench wants a stream
    input  wire logic hpdIn,     // Hot-plug from panel
    output logic      supplyOut, // Panel logic supply
    output logic      videoOut   // Valid video
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int IDLE_CYC = 16; // Idle pattern span
    int idle;                     // Idle cycles sent
    int vidCyc;                   // Cycles of video so far
    int litCyc;                   // Cycles of backlight rail up
    int offCyc;                   // Cycles since backlight enable off
    logic blRail, blDim, blEnable; // Backlight rail, dimming, enable
    wire vidGo = videoReq && powerReq && hpdIn && idle == IDLE_CYC;
    wire lightWant = videoReq && powerReq && videoOut && vidCyc >= 80 * CYC_MS;
    initial begin
        supplyOut = 1'b0;
        videoOut = 1'b0;
        idle = 0;
        vidCyc = 0;
        litCyc = 0;
        offCyc = 50 * CYC_MS;
        blRail = 1'b0;
        blDim = 1'b0;
        blEnable = 1'b0;
    end
    // Train after hot-plug, idle, then stream
    always @(posedge core_clk) begin
        supplyOut <= powerReq;
        if (!hpdIn || !powerReq) begin
            idle <= 0;
        end else if (idle < IDLE_CYC) begin
            idle <= idle + 1;
        end
        // Video stops once the backlight has been dark for 50 ms, or at once when power is withdrawn
        videoOut <= vidGo || (videoOut && powerReq && (blEnable || offCyc < 50 * CYC_MS));
        vidCyc <= videoOut ? ((vidCyc < 80 * CYC_MS) ? vidCyc + 1 : vidCyc) : 0;
        litCyc <= blRail ? ((litCyc < CYC_MS) ? litCyc + 1 : litCyc) : 0;
        offCyc <= blEnable ? 0 : ((offCyc < 50 * CYC_MS) ? offCyc + 1 : offCyc);
        blRail <= lightWant || (blRail && (blDim || offCyc < CYC_MS));
        blDim <= lightWant && blRail && litCyc >= CYC_MS;
        blEnable <= lightWant && blDim;
    end
endmodule : source_model
